/* File: hdl/sub_map.vh */
/*
 register map, field positions, codes and reset values of the
 user-bit buffer and transmitter configuration bank.
 assumes: included by the bank module only; byte offsets on a 32-bit AXI4-Lite bus.
*/
// Operation
// - dat category: user irq only on id change in rx mode 10 with pro bit clear
// - rx user split selects shared or A/B buffers
// - cs irq mode 0 flags every block
// - cs irq mode 1 flags changed first bytes
// - rx mode 00 discards, 01 double buffers
// - rx mode 10 formats by pro bit
// - rx buffer size 384 or 768 bits
// - validity bit driven from tx_validity_bit
// - tx_rate_ratio selects tx to rx ratio
// - tx_clk_source picks transmitter clock
// - transmitter runs only while tx_on set
// - tx_iu_zero_count zeros between information units
// - tx user split selects shared or separate
// - tx mode 00 sends zero user bits
// - tx mode 10 accepts information units
// - tx buffer size 384 or 768 bits
// - receive config at 0x0b, bits 7:6 reserved
`ifndef SUB_MAP_VH
`define SUB_MAP_VH

// byte offsets: the printed 0x0b/0x0c/0x0d are indices, address is index * 4
`define SUB_IDX_RXCFG 8'h0b
`define SUB_IDX_TXCTL 8'h0c
`define SUB_IDX_TXBUF 8'h0d
`define SUB_IDX_STAT 8'h20
`define SUB_IDX_CLR 8'h21
`define SUB_IDX_IEN 8'h22
`define SUB_IDX_LIVE 8'h23

// receive buffer config fields
`define SUB_RX_DAT 5
`define SUB_RX_SPLIT 4
`define SUB_RX_CSMODE 3
`define SUB_RX_MODE_HI 2
`define SUB_RX_MODE_LO 1
`define SUB_RX_SIZE 0
`define SUB_RX_MASK 8'h3f

// transmitter control fields
`define SUB_TX_VAL 6
`define SUB_TX_RAT_HI 5
`define SUB_TX_RAT_LO 3
`define SUB_TX_CLK_HI 2
`define SUB_TX_CLK_LO 1
`define SUB_TX_EN 0
`define SUB_TXCTL_MASK 8'h7f

// transmit buffer config fields
`define SUB_TX_IUZ_HI 7
`define SUB_TX_IUZ_LO 4
`define SUB_TX_SPLIT 3
`define SUB_TX_MODE_HI 2
`define SUB_TX_MODE_LO 1
`define SUB_TX_SIZE 0

// mode codes
`define SUB_UB_OFF 2'h0
`define SUB_UB_DBL 2'h1
`define SUB_UB_IEC 2'h2
`define SUB_UB_RSV 2'h3
`define SUB_CLK_RSV 2'h3
`define SUB_IUZ_MAX 4'h8

// buffer sizes in user bits, channel-status block length in frames and compare width in bits
`define SUB_BUF_SMALL 10'h180
`define SUB_BUF_LARGE 10'h300
`define SUB_CS_FRAMES 8'hc0
`define SUB_CS_CMP_BITS 6'h28

// status bits
`define SUB_ST_CS 0
`define SUB_ST_UB 1
`define SUB_ST_W 2

`define SUB_RESET_BYTE 8'h00
`define SUB_RESP_OKAY 2'h0
`define SUB_RESP_SLVERR 2'h2

`endif

/* File: hdl/sub_cfg_bank.v */
/*
 user-bit buffer and transmitter configuration bank with AXI4-Lite slave,
 frame-boundary commit of settings, channel-status block and user-bit
 interrupt event logic.
 assumes: receiver and transmitter cores on aclk present frame strobes and
 per-frame channel-status / user bits as single-cycle synchronous signals.
*/
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "sub_map.vh"

module sub_cfg_bank (
   input wire aclk,
   input wire aresetn,
   // axi4-lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // receiver path events
   input wire rx_frame_strobe,
   input wire rx_block_start,
   input wire rx_cs_bit,
   input wire rx_user_bit,
   input wire rx_pro_flag,
   input wire rx_dat_category,
   input wire rx_iu_start_bit,
   input wire rx_user_event,
   // transmitter path
   input wire tx_frame_strobe,
   input wire tx_user_bit_in,
   // applied receiver settings
   output reg rx_user_store,
   output reg rx_user_split,
   output reg [9:0] rx_user_buf_bits,
   output reg rx_user_dbl_buf,
   output reg rx_user_fmt_iec,
   output reg rx_user_fmt_pro,
   // applied transmitter settings
   output reg tx_on,
   output reg tx_validity_bit,
   output reg [2:0] tx_rate_ratio,
   output reg [1:0] tx_clk_source,
   output reg [3:0] tx_iu_zero_count,
   output reg tx_user_split,
   output reg [9:0] tx_user_buf_bits,
   output reg tx_user_dbl_buf,
   output reg tx_user_iu_mode,
   output reg tx_user_bit_out,
   output wire irq
);

   // host-visible shadows: read back what was written, with reserved bits as zero
   reg [7:0] rxcfg_reg;
   reg [7:0] txctl_reg;
   reg [7:0] txbuf_reg;
   reg [`SUB_ST_W-1:0] stat_reg;
   reg [`SUB_ST_W-1:0] ien_reg;
   reg [7:0] frame_cnt_reg;
   reg [39:0] cs_cur_reg;
   reg [39:0] cs_prev_reg;
   reg cs_seen_reg;
   reg iu_last_reg;

   // write channel holding registers
   reg aw_full_reg;
   reg [7:0] aw_addr_reg;
   reg w_full_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;

   // buffer size decode shared by both directions
   function [9:0] buf_bits;
      input size_sel;
      begin
         buf_bits = size_sel ? `SUB_BUF_LARGE : `SUB_BUF_SMALL;
      end
   endfunction

   // byte index of an aligned address; low two bits ignored
   function [7:0] reg_index;
      input [7:0] addr;
      begin
         reg_index = {2'h0, addr[7:2]};
      end
   endfunction

   wire [7:0] wr_idx = reg_index(aw_addr_reg);
   wire wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
   wire wr_lane0 = w_strb_reg[0];

   // one slot each; refuse new address/data until the held write fires
   assign s_axi_awready = !aw_full_reg;
   assign s_axi_wready = !w_full_reg;
   assign s_axi_arready = !s_axi_rvalid;

   // write channels taken in either order, response once both are in
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_full_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SUB_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (wr_idx)
               `SUB_IDX_RXCFG, `SUB_IDX_TXCTL, `SUB_IDX_TXBUF,
               `SUB_IDX_CLR, `SUB_IDX_IEN: s_axi_bresp <= `SUB_RESP_OKAY;
               default: s_axi_bresp <= `SUB_RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration shadows; reserved bits forced to zero on write
   always @(posedge aclk) begin
      if (!aresetn) begin
         rxcfg_reg <= `SUB_RESET_BYTE;
         txctl_reg <= `SUB_RESET_BYTE;
         txbuf_reg <= `SUB_RESET_BYTE;
         ien_reg <= {`SUB_ST_W{1'b0}};
      end else if (wr_fire && wr_lane0) begin
         case (wr_idx)
            `SUB_IDX_RXCFG: rxcfg_reg <= w_data_reg[7:0] & `SUB_RX_MASK;
            `SUB_IDX_TXCTL: txctl_reg <= w_data_reg[7:0] & `SUB_TXCTL_MASK;
            `SUB_IDX_TXBUF: txbuf_reg <= w_data_reg[7:0];
            `SUB_IDX_IEN: ien_reg <= w_data_reg[`SUB_ST_W-1:0];
            default: ;
         endcase
      end
   end

   // read channel: one register per aligned word, bits above read zero
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SUB_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `SUB_RESP_OKAY;
         case (reg_index(s_axi_araddr))
            `SUB_IDX_RXCFG: s_axi_rdata <= {24'h000000, rxcfg_reg};
            `SUB_IDX_TXCTL: s_axi_rdata <= {24'h000000, txctl_reg};
            `SUB_IDX_TXBUF: s_axi_rdata <= {24'h000000, txbuf_reg};
            `SUB_IDX_STAT: s_axi_rdata <= {30'h00000000, stat_reg};
            `SUB_IDX_CLR: s_axi_rdata <= 32'h00000000;
            `SUB_IDX_IEN: s_axi_rdata <= {30'h00000000, ien_reg};
            // applied (live) state, shows whether the frame commit happened
            `SUB_IDX_LIVE: s_axi_rdata <= {29'h00000000, tx_on, rx_user_store, rx_user_split};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `SUB_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // receive settings committed only at a receive frame boundary, so a
   // half-stored frame never sees a new layout
   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_user_store <= 1'b0;
         rx_user_split <= 1'b0;
         rx_user_buf_bits <= `SUB_BUF_SMALL;
         rx_user_dbl_buf <= 1'b0;
         rx_user_fmt_iec <= 1'b0;
         rx_user_fmt_pro <= 1'b0;
      end else if (rx_frame_strobe) begin
         rx_user_split <= rxcfg_reg[`SUB_RX_SPLIT];
         rx_user_buf_bits <= buf_bits(rxcfg_reg[`SUB_RX_SIZE]);
         case (rxcfg_reg[`SUB_RX_MODE_HI:`SUB_RX_MODE_LO])
            `SUB_UB_DBL: begin
               rx_user_store <= 1'b1;
               rx_user_dbl_buf <= 1'b1;
               rx_user_fmt_iec <= 1'b0;
               rx_user_fmt_pro <= 1'b0;
            end
            `SUB_UB_IEC: begin
               rx_user_store <= 1'b1;
               rx_user_dbl_buf <= 1'b0;
               rx_user_fmt_pro <= rx_pro_flag;
               rx_user_fmt_iec <= !rx_pro_flag;
            end
            default: begin // off, and reserved treated as off
               rx_user_store <= 1'b0;
               rx_user_dbl_buf <= 1'b0;
               rx_user_fmt_iec <= 1'b0;
               rx_user_fmt_pro <= 1'b0;
            end
         endcase
      end
   end

   // transmit settings committed at a transmit frame boundary
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_on <= 1'b0;
         tx_validity_bit <= 1'b0;
         tx_rate_ratio <= 3'h0;
         tx_clk_source <= 2'h0;
         tx_iu_zero_count <= 4'h0;
         tx_user_split <= 1'b0;
         tx_user_buf_bits <= `SUB_BUF_SMALL;
         tx_user_dbl_buf <= 1'b0;
         tx_user_iu_mode <= 1'b0;
      end else begin
         // disabling is immediate; enabling waits for a frame edge
         if (!txctl_reg[`SUB_TX_EN])
            tx_on <= 1'b0;
         if (tx_frame_strobe) begin
            tx_on <= txctl_reg[`SUB_TX_EN];
            tx_validity_bit <= txctl_reg[`SUB_TX_VAL];
            tx_rate_ratio <= txctl_reg[`SUB_TX_RAT_HI:`SUB_TX_RAT_LO];
            // reserved source code leaves the previous clock in place
            if (txctl_reg[`SUB_TX_CLK_HI:`SUB_TX_CLK_LO] != `SUB_CLK_RSV)
               tx_clk_source <= txctl_reg[`SUB_TX_CLK_HI:`SUB_TX_CLK_LO];
            // counts above eight saturate at the documented maximum
            if (txbuf_reg[`SUB_TX_IUZ_HI:`SUB_TX_IUZ_LO] > `SUB_IUZ_MAX)
               tx_iu_zero_count <= `SUB_IUZ_MAX;
            else
               tx_iu_zero_count <= txbuf_reg[`SUB_TX_IUZ_HI:`SUB_TX_IUZ_LO];
            tx_user_split <= txbuf_reg[`SUB_TX_SPLIT];
            tx_user_buf_bits <= buf_bits(txbuf_reg[`SUB_TX_SIZE]);
            tx_user_dbl_buf <=
               txbuf_reg[`SUB_TX_MODE_HI:`SUB_TX_MODE_LO] == `SUB_UB_DBL;
            tx_user_iu_mode <=
               txbuf_reg[`SUB_TX_MODE_HI:`SUB_TX_MODE_LO] == `SUB_UB_IEC;
         end
      end
   end

   // outgoing user bit: zero in mode 00 (and reserved) or while disabled
   always @(posedge aclk) begin
      if (!aresetn)
         tx_user_bit_out <= 1'b0;
      else if (tx_user_dbl_buf || tx_user_iu_mode)
         tx_user_bit_out <= tx_on & tx_user_bit_in;
      else
         tx_user_bit_out <= 1'b0;
   end

   // channel-status block capture: first 40 bits compared block to block
   wire cs_last_frame = rx_frame_strobe && (frame_cnt_reg == `SUB_CS_FRAMES - 8'h01);
   wire cs_changed = !cs_seen_reg || (cs_cur_reg != cs_prev_reg);
   wire cs_event = cs_last_frame &&
      (rxcfg_reg[`SUB_RX_CSMODE] ? cs_changed : 1'b1);

   always @(posedge aclk) begin
      if (!aresetn) begin
         frame_cnt_reg <= 8'h00;
         cs_cur_reg <= 40'h0000000000;
         cs_prev_reg <= 40'h0000000000;
         cs_seen_reg <= 1'b0;
      end else if (rx_frame_strobe) begin
         if (rx_block_start) begin
            frame_cnt_reg <= 8'h01;
            cs_cur_reg <= {39'h0000000000, rx_cs_bit};
         end else begin
            frame_cnt_reg <= frame_cnt_reg + 8'h01;
            if (frame_cnt_reg < {2'h0, `SUB_CS_CMP_BITS})
               cs_cur_reg <= {cs_cur_reg[38:0], rx_cs_bit};
         end
         if (cs_last_frame) begin
            cs_prev_reg <= cs_cur_reg;
            cs_seen_reg <= 1'b1;
            frame_cnt_reg <= 8'h00;
         end
      end
   end

   // user-bit event, gated to id-bit changes for dat material
   wire dat_gate = rxcfg_reg[`SUB_RX_DAT] && rx_user_fmt_iec && rx_dat_category;
   wire ub_event = rx_user_event && rx_user_store &&
      (dat_gate ? (rx_iu_start_bit != iu_last_reg) : 1'b1);

   always @(posedge aclk) begin
      if (!aresetn)
         iu_last_reg <= 1'b0;
      else if (rx_user_event)
         iu_last_reg <= rx_iu_start_bit;
   end

   // sticky status: a new event in the clearing cycle wins over the clear
   wire clr_hit = wr_fire && wr_lane0 && (wr_idx == `SUB_IDX_CLR);
   wire [`SUB_ST_W-1:0] clr_mask = clr_hit ? w_data_reg[`SUB_ST_W-1:0] : {`SUB_ST_W{1'b0}};
   wire [`SUB_ST_W-1:0] set_mask = {ub_event, cs_event};

   always @(posedge aclk) begin
      if (!aresetn)
         stat_reg <= {`SUB_ST_W{1'b0}};
      else
         stat_reg <= (stat_reg & ~clr_mask) | set_mask;
   end

   assign irq = |(stat_reg & ien_reg);

   // rx_user_bit is consumed by the buffer core; kept on the port for it
   wire unused_ok = rx_user_bit;

endmodule // sub_cfg_bank

/* File: bench/sub_cfg_assertions.sv */
/* checker for the configuration bank: bus answers, frame commit, field ranges.
 assumes: bound onto sub_cfg_bank, one aclk domain, sync active-low reset. */
`timescale 1ns/1ps
module sub_cfg_checker (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire rx_frame_strobe,
   input wire tx_frame_strobe,
   input wire [9:0] rx_user_buf_bits,
   input wire tx_on,
   input wire tx_validity_bit,
   input wire [2:0] tx_rate_ratio,
   input wire [1:0] tx_clk_source,
   input wire [3:0] tx_iu_zero_count,
   input wire tx_user_bit_in,
   input wire tx_user_bit_out,
   input wire irq
);
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // answers stand until the master takes them
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before bready");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed before rready");
   // applied settings move only at a frame boundary, except tx_on falling; reset release is exempt
   rxsize_commit_a: assert property ($changed(rx_user_buf_bits) |-> $past(rx_frame_strobe) || !$past(aresetn))
      else $error("rx buffer size changed off a frame");
   valid_commit_a: assert property ($changed(tx_validity_bit) |-> $past(tx_frame_strobe) || !$past(aresetn))
      else $error("validity bit changed off a frame");
   ratio_commit_a: assert property ($changed(tx_rate_ratio) |-> $past(tx_frame_strobe) || !$past(aresetn))
      else $error("rate ratio changed off a frame");
   txon_start_a: assert property ($rose(tx_on) |-> $past(tx_frame_strobe))
      else $error("transmitter started off a frame");
   // field ranges: reserved codes never reach the cores
   rxsize_legal_a: assert property (rx_user_buf_bits == 10'h180 || rx_user_buf_bits == 10'h300)
      else $error("rx buffer size not 384 or 768");
   clk_legal_a: assert property (tx_clk_source != 2'h3)
      else $error("reserved clock source applied");
   zero_cap_a: assert property (tx_iu_zero_count <= 4'h8)
      else $error("zero count above eight");
   // a user bit goes out only from the buffer while running
   ubit_gate_a: assert property (tx_user_bit_out |-> $past(tx_user_bit_in) && $past(tx_on))
      else $error("user bit sent without source");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property ($rose(irq));
   cover property ($rose(tx_on));
endmodule // sub_cfg_checker

bind sub_cfg_bank sub_cfg_checker u_sub_chk (.*);

/* File: bench/sub_link_model.sv */
/* far-side stand-in: receiver and transmitter cores giving frame strobes,
 channel-status bits and transmit user bits on aclk.
 assumes: one frame every GAP cycles, 192-frame channel-status blocks. */
`timescale 1ns/1ps
module sub_link_model #(
   parameter GAP = 4
) (
   input wire aclk,
   input wire aresetn,
   input wire cs_flip,
   output reg rx_frame_strobe,
   output reg rx_block_start,
   output reg rx_cs_bit,
   output reg tx_frame_strobe,
   output reg tx_user_bit_in
);
   reg [3:0] pace_reg;
   reg [7:0] frame_reg;
   wire frame_end = (pace_reg == GAP - 1);
   // frame pacing; block wraps after 192 frames, frame 0 is the z preamble
   always @(posedge aclk) begin
      if (!aresetn) begin
         pace_reg <= 4'h0;
         frame_reg <= 8'h00;
      end else begin
         pace_reg <= frame_end ? 4'h0 : pace_reg + 4'h1;
         if (frame_end) begin
            frame_reg <= (frame_reg == 8'hbf) ? 8'h00 : frame_reg + 8'h01;
         end
      end
   end
   // block-start and channel-status bits toggle between frames so a stale read never matches by luck
   always @(posedge aclk) begin
      rx_frame_strobe <= aresetn && frame_end;
      tx_frame_strobe <= aresetn && (pace_reg == 4'h1);
      rx_block_start <= frame_end ? (frame_reg == 8'h00) : ~rx_block_start;
      rx_cs_bit <= frame_end ? (frame_reg[0] ^ cs_flip) : ~rx_cs_bit;
      tx_user_bit_in <= frame_reg[1];
   end
endmodule // sub_link_model

/* File: bench/testbench.sv */
/* self-checking bench for the configuration bank: registers, commit, events.
 assumes: sub_link_model paces frames; single 20 MHz aclk. */
`timescale 1ns/1ps
module testbench;
   localparam [31:0] ALL = 32'hffffffff;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [7:0] s_axi_awaddr = 8'h00;
   reg [7:0] s_axi_araddr = 8'h00;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   reg s_axi_rready = 1'b0, rx_user_bit = 1'b0, rx_pro_flag = 1'b0, rx_dat_category = 1'b0;
   reg rx_iu_start_bit = 1'b0, rx_user_event = 1'b0, cs_flip = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire rx_frame_strobe, rx_block_start, rx_cs_bit, tx_frame_strobe, tx_user_bit_in;
   wire rx_user_store, rx_user_split, rx_user_dbl_buf, rx_user_fmt_iec, rx_user_fmt_pro;
   wire tx_on, tx_validity_bit, tx_user_split, tx_user_dbl_buf, tx_user_iu_mode, tx_user_bit_out;
   wire [9:0] rx_user_buf_bits, tx_user_buf_bits;
   wire [2:0] tx_rate_ratio;
   wire [1:0] tx_clk_source;
   wire [3:0] tx_iu_zero_count;
   integer err_count = 0, samples_checked = 0, cyc_count = 0;

   sub_cfg_bank dut (.*);
   sub_link_model link (.*);

   always #25 aclk = ~aclk;
   // hang guard, well past the longest status wait
   always @(posedge aclk) begin
      cyc_count <= cyc_count + 1;
      if (cyc_count == 20000) begin
         err_count = err_count + 1;
         tally_and_finish;
      end
   end

   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", samples_checked, err_count);
         if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask

   task chk(input [8*10:1] nm, input [31:0] exp, input [31:0] got);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask

   task tick(input integer k);
      repeat (k) @(posedge aclk);
   endtask

   // bready comes one edge late so the standing response is exercised
   // no cycle count assumed: only the hang guard ends a missing answer
   task wr(input [7:0] a, input [31:0] d, input [1:0] er);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (!s_axi_bvalid);
         s_axi_bready <= 1'b1;
         @(posedge aclk);
         s_axi_bready <= 1'b0;
         chk("bresp", {1'b1, er}, {s_axi_bvalid, s_axi_bresp});
      end
   endtask

   task rd(input [7:0] a, input [31:0] m, input [31:0] ed, input [1:0] er);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (!s_axi_rvalid);
         s_axi_rready <= 1'b1;
         @(posedge aclk);
         s_axi_rready <= 1'b0;
         chk("rdata", ed, s_axi_rdata & m);
         chk("rresp", {1'b1, er}, {s_axi_rvalid, s_axi_rresp});
      end
   endtask

   // wait for a frame of one path, then let its commit land
   task sync(input t);
      integer n;
      begin
         n = 0;
         do begin
            @(posedge aclk);
            n = n + 1;
         end while (!(t ? tx_frame_strobe : rx_frame_strobe) && n < 20);
         @(posedge aclk);
      end
   endtask

   task watch(input e);
      integer n, k;
      begin
         k = 0;
         for (n = 0; n < 40; n = n + 1) begin
            @(posedge aclk);
            k = k + tx_user_bit_out;
         end
         chk("userbit", e, k != 0);
      end
   endtask

   task rxcase(input [7:0] cf, input p, input [14:0] ex);
      begin
         rx_pro_flag <= p;
         wr(8'h2c, {24'h0, cf}, 2'h0);
         sync(1'b0);
         chk("rxapply", ex, {rx_user_store, rx_user_split, rx_user_dbl_buf, rx_user_fmt_iec,
            rx_user_fmt_pro, rx_user_buf_bits});
      end
   endtask

   task ev(input id);
      begin
         rx_iu_start_bit <= id;
         rx_user_event <= 1'b1;
         @(posedge aclk);
         rx_user_event <= 1'b0;
         tick(2);
      end
   endtask

   task waitirq(input e);
      integer n;
      begin
         n = 0;
         do begin
            @(posedge aclk);
            n = n + 1;
         // a change can miss the compare window and flag only a block later
         end while (!irq && n < 1600);
         chk("irq", e, irq);
      end
   endtask

   task t_regs;
      begin
         rd(8'h2c, ALL, 32'h0, 2'h0);
         rd(8'h34, ALL, 32'h0, 2'h0);
         rd(8'h44, ALL, 32'h0, 2'h2);
         wr(8'h44, 32'h5a, 2'h2);
         wr(8'h2c, 32'h3b, 2'h0);
         rd(8'h2c, ALL, 32'h3b, 2'h0);
         wr(8'h34, 32'ha5, 2'h0);
         rd(8'h34, ALL, 32'ha5, 2'h0);
         wr(8'h30, 32'h6b, 2'h0);
         rd(8'h30, ALL, 32'h6b, 2'h0);
         rd(8'h84, ALL, 32'h0, 2'h0);
      end
   endtask

   task t_tx;
      integer i;
      reg [2:0] r;
      reg [1:0] c;
      begin
         for (i = 0; i < 5; i = i + 1) begin
            r = (i > 2) ? i + 2 : i;
            c = i % 3;
            wr(8'h30, {25'h0, i[0], r, c, 1'b1}, 2'h0);
            sync(1'b1);
            chk("ratio", r, tx_rate_ratio);
            chk("clksrc", c, tx_clk_source);
            chk("validity", i[0], tx_validity_bit);
            chk("txon", 1'b1, tx_on);
         end
         wr(8'h30, 32'h4, 2'h0);
         sync(1'b1);
         chk("clkoff", {2'h2, 1'b0}, {tx_clk_source, tx_on});
      end
   endtask

   task t_txbuf;
      integer i;
      begin
         for (i = 0; i < 10; i = i + 1) begin
            wr(8'h34, {24'h0, i[3:0], 4'h0}, 2'h0);
            sync(1'b1);
            chk("zeros", (i > 8) ? 8 : i, tx_iu_zero_count);
         end
         wr(8'h30, 32'h1, 2'h0);
         wr(8'h34, 32'h8, 2'h0);
         sync(1'b1);
         chk("txsplit", 1'b1, tx_user_split);
         watch(1'b0);
         wr(8'h34, 32'h2, 2'h0);
         sync(1'b1);
         chk("txsmall", {2'h1, 10'h180}, {tx_user_split, tx_user_dbl_buf, tx_user_buf_bits});
         wr(8'h34, 32'h3, 2'h0);
         sync(1'b1);
         chk("txlarge", {1'b1, 10'h300}, {tx_user_dbl_buf, tx_user_buf_bits});
         watch(1'b1);
         wr(8'h34, 32'h4, 2'h0);
         sync(1'b1);
         chk("txiu", 2'h2, {tx_user_iu_mode, tx_user_dbl_buf});
         wr(8'h30, 32'h0, 2'h0);
         watch(1'b0);
      end
   endtask

   task t_irq;
      begin
         wr(8'h88, 32'h2, 2'h0);
         rxcase(8'h02, 1'b0, {5'h14, 10'h180});
         wr(8'h84, 32'h3, 2'h0);
         ev(1'b0);
         chk("irq", 1'b1, irq);
         wr(8'h84, 32'h2, 2'h0);
         chk("irq", 1'b0, irq);
         wr(8'h88, 32'h0, 2'h0);
         ev(1'b0);
         chk("irq", 1'b0, irq);
         rd(8'h80, 32'h2, 32'h2, 2'h0);
         wr(8'h88, 32'h2, 2'h0);
         rx_dat_category <= 1'b1;
         rxcase(8'h24, 1'b0, {5'h12, 10'h180});
         rd(8'h8c, ALL, 32'h2, 2'h0);
         ev(1'b1);
         wr(8'h84, 32'h2, 2'h0);
         ev(1'b1);
         chk("irq", 1'b0, irq);
         ev(1'b0);
         chk("irq", 1'b1, irq);
      end
   endtask

   task t_cs;
      begin
         rx_dat_category <= 1'b0;
         wr(8'h88, 32'h1, 2'h0);
         wr(8'h2c, 32'h0, 2'h0);
         wr(8'h84, 32'h1, 2'h0);
         waitirq(1'b1);
         wr(8'h84, 32'h1, 2'h0);
         waitirq(1'b1);
         wr(8'h2c, 32'h8, 2'h0);
         tick(800);
         wr(8'h84, 32'h1, 2'h0);
         waitirq(1'b0);
         cs_flip <= 1'b1;
         waitirq(1'b1);
      end
   endtask

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_tx;
      rxcase(8'h00, 1'b0, {5'h00, 10'h180});
      rxcase(8'h12, 1'b0, {5'h1c, 10'h180});
      rxcase(8'h03, 1'b0, {5'h14, 10'h300});
      rxcase(8'h04, 1'b0, {5'h12, 10'h180});
      rxcase(8'h04, 1'b1, {5'h11, 10'h180});
      rxcase(8'h10, 1'b0, {5'h08, 10'h180});
      t_txbuf;
      t_irq;
      t_cs;
      tally_and_finish;
   end
endmodule // testbench
